// file: smlc_monitor.sv
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module smlc_monitor
    import smlc_pkg::*;
#(
    parameter int unsigned DET_N    = 8,
    parameter int unsigned PART_N   = 4,
    parameter logic [31:0] MEM_TOP  = 32'h0010_0000,
    parameter logic [31:0] TEST_KEY = 32'h5A5A_A5A5
)
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    input  wire logic [7:0]       i_addr,
    input  wire logic [31:0]      i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    input  wire logic             i_priv,
    output var  logic [31:0]      o_rdata,
    input  wire logic [DET_N-1:0] i_det,
    input  wire smlc_acc_s        i_acc,
    input  wire logic             i_nvm_normal,
    input  wire logic             i_tcmd_valid,
    input  wire logic             i_tcmd_func,
    output var  logic             o_sys_reset,
    output var  logic             o_det_alarm,
    output var  logic             o_acc_trap,
    output var  logic             o_acc_inval,
    output var  logic             o_tcmd_accept,
    output var  logic             o_tcmd_reject,
    output var  logic             o_boot_flash,
    output var  logic             o_lc_normal,
    output var  logic             o_nvm_set_normal
);

    // State
    logic [DET_N-1:0] det_flag;
    logic [DET_N-1:0] next_det_flag;
    logic             evt_flag;
    logic             next_evt_flag;
    logic [HOLD_W-1:0] hold_cnt;
    logic [HOLD_W-1:0] next_hold_cnt;
    logic [1:0]       ctrl;
    logic [1:0]       next_ctrl;
    logic [2:0]       viol;
    logic [2:0]       next_viol;
    smlc_lc_e         lc;
    smlc_lc_e         next_lc;
    logic [31:0]      trace;
    logic [31:0]      next_trace;
    logic [31:0]      next_rdata;
    logic             next_sys_reset;
    logic             next_acc_trap;
    logic             next_acc_inval;
    logic             next_tcmd_accept;
    logic             next_tcmd_reject;
    logic             next_nvm_set_normal;
    smlc_part_s       part      [PART_N];
    logic [PART_N-1:0] part_ok;
    logic [31:0]      part_rd   [PART_N];
    logic [PART_N-1:0] part_sel;

    // Common qualifiers
    logic wr_priv;
    logic any_det;
    logic lc_ready;
    assign wr_priv  = i_wr && i_priv;
    assign any_det  = |i_det;
    assign lc_ready = (lc != LC_LOAD);

    // Detector capture; flags always capture inputs, the summary event flag only while the reset reaction is off
    always_comb
    begin
        next_det_flag = det_flag;
        next_evt_flag = evt_flag;
        if (wr_priv && i_addr == OFS_DET)
        begin
            next_det_flag = det_flag & ~i_wdata[DET_N-1:0];
            if (i_wdata[DET_SUMMARY])
            begin
                next_evt_flag = 1'b0;
            end
        end
        next_det_flag = next_det_flag | i_det;
        if (any_det && !ctrl[CTRL_REACT_RST])
        begin
            next_evt_flag = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            det_flag <= '0;
            evt_flag <= 1'b0;
        end
        else
        begin
            det_flag <= next_det_flag;
            evt_flag <= next_evt_flag;
        end
    end

    // Reset reaction: reload while a detector stays active so the
    // device is held in reset for the whole failure plus a stretch
    always_comb
    begin
        next_hold_cnt = hold_cnt;
        if (any_det && ctrl[CTRL_REACT_RST])
        begin
            next_hold_cnt = HOLD_W'(RST_HOLD_CYC);
        end
        else if (hold_cnt != '0)
        begin
            next_hold_cnt = hold_cnt - HOLD_W'(1);
        end
        next_sys_reset = (next_hold_cnt != '0);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            hold_cnt    <= '0;
            o_sys_reset <= 1'b0;
            o_det_alarm <= 1'b0;
        end
        else
        begin
            hold_cnt    <= next_hold_cnt;
            o_sys_reset <= next_sys_reset;
            o_det_alarm <= next_evt_flag;
        end
    end

    // Control register: reaction choice and boot source
    always_comb
    begin
        next_ctrl = ctrl;
        if (wr_priv && i_addr == OFS_CTRL)
        begin
            next_ctrl = i_wdata[1:0];
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            ctrl         <= CTRL_RST;
            o_boot_flash <= CTRL_RST[CTRL_BOOT];
        end
        else
        begin
            ctrl         <= next_ctrl;
            o_boot_flash <= next_ctrl[CTRL_BOOT];
        end
    end

    // Partition registers and per-entry access match
    genvar gi;
    generate
        for (gi = 0; gi < PART_N; gi++)
        begin : g_part
            smlc_part_s next_part;
            logic [7:0] ofs;
            assign ofs = OFS_PART + 8'(gi) * PART_STRIDE;

            always_comb
            begin
                next_part = part[gi];
                if (wr_priv && i_addr == ofs + PART_OFS_BASE)
                begin
                    next_part.base = i_wdata;
                end
                if (wr_priv && i_addr == ofs + PART_OFS_LIMIT)
                begin
                    next_part.limit = i_wdata;
                end
                if (wr_priv && i_addr == ofs + PART_OFS_ATTR)
                begin
                    next_part.attr = i_wdata[1:0];
                end
            end

            always_ff @(posedge i_ref_clk)
            begin
                if (i_rst)
                begin
                    part[gi] <= '{base: BASE_RST, limit: LIMIT_RST, attr: ATTR_RST};
                end
                else
                begin
                    part[gi] <= next_part;
                end
            end

            // User access must fall in a partition whose attribute allows it
            assign part_ok[gi] = (i_acc.addr >= part[gi].base) && (i_acc.addr <= part[gi].limit)
                                 && (i_acc.write ? part[gi].attr[ATTR_UW] : part[gi].attr[ATTR_UR]);
            assign part_sel[gi] = (i_addr == ofs + PART_OFS_BASE) || (i_addr == ofs + PART_OFS_LIMIT)
                                  || (i_addr == ofs + PART_OFS_ATTR);
            assign part_rd[gi]  = (i_addr == ofs + PART_OFS_BASE)  ? part[gi].base :
                                  (i_addr == ofs + PART_OFS_LIMIT) ? part[gi].limit :
                                  (i_addr == ofs + PART_OFS_ATTR)  ? {30'h0, part[gi].attr} : 32'h0;
        end
    endgenerate

    // Access checker; until the lifecycle is known every access is trapped
    logic acc_inval;
    logic acc_prohib;
    always_comb
    begin
        acc_inval  = i_acc.addr >= MEM_TOP;
        acc_prohib = !lc_ready || acc_inval || (i_acc.user && !(|part_ok));
        next_acc_trap  = i_acc.valid && acc_prohib;
        next_acc_inval = i_acc.valid && acc_inval;
    end

    // Violation flags; hardware set wins over a software clear
    logic key_wr;
    logic key_bad;
    logic trace_wr;
    logic trace_bad;
    assign key_wr    = i_wr && i_addr == OFS_KEY;
    assign key_bad   = key_wr && !(lc == LC_TEST_LOCKED && i_wdata == TEST_KEY);
    assign trace_wr  = i_wr && i_addr == OFS_TRACE;
    assign trace_bad = trace_wr && (lc != LC_TEST_OPEN);

    always_comb
    begin
        next_viol = viol;
        if (wr_priv && i_addr == OFS_VIOL)
        begin
            next_viol = viol & ~i_wdata[2:0];
        end
        if (next_acc_trap)
        begin
            next_viol[VIOL_TRAP] = 1'b1;
        end
        if (next_acc_inval)
        begin
            next_viol[VIOL_INVAL] = 1'b1;
        end
        if (key_bad || trace_bad)
        begin
            next_viol[VIOL_REFUSE] = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            viol        <= '0;
            o_acc_trap  <= 1'b0;
            o_acc_inval <= 1'b0;
        end
        else
        begin
            viol        <= next_viol;
            o_acc_trap  <= next_acc_trap;
            o_acc_inval <= next_acc_inval;
        end
    end

    // Lifecycle: loaded from storage, password opens test, normal is final
    always_comb
    begin
        next_lc             = lc;
        next_nvm_set_normal = 1'b0;
        case (lc)
            LC_LOAD:
            begin
                next_lc = i_nvm_normal ? LC_NORMAL_MODE : LC_TEST_LOCKED;
            end
            LC_TEST_LOCKED:
            begin
                if (key_wr && !key_bad)
                begin
                    next_lc = LC_TEST_OPEN;
                end
                if (wr_priv && i_addr == OFS_LC && i_wdata[LC_NORMAL])
                begin
                    next_lc             = LC_NORMAL_MODE;
                    next_nvm_set_normal = 1'b1;
                end
            end
            LC_TEST_OPEN:
            begin
                if (wr_priv && i_addr == OFS_LC && i_wdata[LC_NORMAL])
                begin
                    next_lc             = LC_NORMAL_MODE;
                    next_nvm_set_normal = 1'b1;
                end
            end
            LC_NORMAL_MODE:
            begin
                next_lc = LC_NORMAL_MODE;
            end
            default:
            begin
                next_lc = LC_LOAD;
            end
        endcase
    end

    // Test commands only in an opened test mode
    always_comb
    begin
        next_tcmd_accept = i_tcmd_valid && (lc == LC_TEST_OPEN);
        next_tcmd_reject = i_tcmd_valid && (lc != LC_TEST_OPEN);
    end

    // Trace data writable only while test is open
    always_comb
    begin
        next_trace = trace;
        if (trace_wr && !trace_bad)
        begin
            next_trace = i_wdata;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            lc               <= LC_LOAD;
            trace            <= TRACE_RST;
            o_lc_normal      <= 1'b0;
            o_nvm_set_normal <= 1'b0;
            o_tcmd_accept    <= 1'b0;
            o_tcmd_reject    <= 1'b0;
        end
        else
        begin
            lc               <= next_lc;
            trace            <= next_trace;
            o_lc_normal      <= (next_lc == LC_NORMAL_MODE);
            o_nvm_set_normal <= next_nvm_set_normal;
            o_tcmd_accept    <= next_tcmd_accept;
            o_tcmd_reject    <= next_tcmd_reject;
        end
    end

    // Read mux; control and partition registers read as zero without privilege
    always_comb
    begin
        next_rdata = 32'h0;
        if (i_rd)
        begin
            case (i_addr)
                OFS_DET:
                begin
                    next_rdata[DET_N-1:0]  = det_flag;
                    next_rdata[DET_SUMMARY] = evt_flag;
                end
                OFS_VIOL:
                begin
                    next_rdata[2:0] = viol;
                end
                OFS_CTRL:
                begin
                    next_rdata[1:0] = i_priv ? ctrl : 2'h0;
                end
                OFS_LC:
                begin
                    next_rdata[LC_NORMAL] = (lc == LC_NORMAL_MODE);
                    next_rdata[LC_OPEN]   = (lc == LC_TEST_OPEN);
                    next_rdata[LC_READY]  = lc_ready;
                end
                OFS_TRACE:
                begin
                    next_rdata = trace;
                end
                default:
                begin
                    for (int k = 0; k < PART_N; k++)
                    begin
                        if (part_sel[k] && i_priv)
                        begin
                            next_rdata = part_rd[k];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_rdata <= 32'h0;
        end
        else
        begin
            o_rdata <= next_rdata;
        end
    end

endmodule
`default_nettype wire

// file: smlc_pkg.sv
package smlc_pkg;
    // Register byte offsets on the plain register port
    localparam logic [7:0]  OFS_DET        = 8'h00;
    localparam logic [7:0]  OFS_CTRL       = 8'h04;
    localparam logic [7:0]  OFS_VIOL       = 8'h08;
    localparam logic [7:0]  OFS_LC         = 8'h0C;
    localparam logic [7:0]  OFS_KEY        = 8'h10;
    localparam logic [7:0]  OFS_TRACE      = 8'h14;
    localparam logic [7:0]  OFS_PART       = 8'h40;
    localparam logic [7:0]  PART_STRIDE    = 8'h10;
    localparam logic [7:0]  PART_OFS_BASE  = 8'h00;
    localparam logic [7:0]  PART_OFS_LIMIT = 8'h04;
    localparam logic [7:0]  PART_OFS_ATTR  = 8'h08;
    // Field positions
    localparam int unsigned CTRL_REACT_RST = 0;
    localparam int unsigned CTRL_BOOT      = 1;
    localparam int unsigned VIOL_TRAP      = 0;
    localparam int unsigned VIOL_INVAL     = 1;
    localparam int unsigned VIOL_REFUSE    = 2;
    localparam int unsigned LC_NORMAL      = 0;
    localparam int unsigned LC_OPEN        = 1;
    localparam int unsigned LC_READY       = 2;
    localparam int unsigned ATTR_UR        = 0;
    localparam int unsigned ATTR_UW        = 1;
    localparam int unsigned DET_SUMMARY    = 31;
    // Values after reset
    localparam logic [1:0]  CTRL_RST       = 2'h1;
    localparam logic [31:0] BASE_RST       = 32'h0000_0000;
    localparam logic [31:0] LIMIT_RST      = 32'h0000_0000;
    localparam logic [1:0]  ATTR_RST       = 2'h0;
    localparam logic [31:0] TRACE_RST      = 32'h0000_0000;
    // Reset stretch after a detector event
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned RST_HOLD_NS    = 100;
    localparam int unsigned RST_HOLD_CYC   = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_W         = 8;

    typedef enum logic [1:0] {LC_LOAD, LC_TEST_LOCKED, LC_TEST_OPEN, LC_NORMAL_MODE} smlc_lc_e;

    typedef struct packed {
        logic [31:0] base;
        logic [31:0] limit;
        logic [1:0]  attr;
    } smlc_part_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        write;
        logic        user;
    } smlc_acc_s;
endpackage

// file: smlc_monitor_chk.sv
`timescale 1ns/100ps
`default_nettype none
module smlc_monitor_chk
    import smlc_pkg::*;
#(
    parameter int unsigned DET_N    = 8,
    parameter int unsigned PART_N   = 4,
    parameter logic [31:0] MEM_TOP  = 32'h0010_0000,
    parameter logic [31:0] TEST_KEY = 32'h5A5A_A5A5
)
(
    input wire logic             i_ref_clk,
    input wire logic             i_rst,
    input wire logic [7:0]       i_addr,
    input wire logic [31:0]      i_wdata,
    input wire logic             i_wr,
    input wire logic             i_rd,
    input wire logic             i_priv,
    input wire logic [31:0]      o_rdata,
    input wire logic [DET_N-1:0] i_det,
    input wire smlc_acc_s        i_acc,
    input wire logic             i_nvm_normal,
    input wire logic             i_tcmd_valid,
    input wire logic             i_tcmd_func,
    input wire logic             o_sys_reset,
    input wire logic             o_det_alarm,
    input wire logic             o_acc_trap,
    input wire logic             o_acc_inval,
    input wire logic             o_tcmd_accept,
    input wire logic             o_tcmd_reject,
    input wire logic             o_boot_flash,
    input wire logic             o_lc_normal,
    input wire logic             o_nvm_set_normal
);
    logic [1:0] ctrl;
    logic [1:0] next_ctrl;
    logic       det_clr;

    // Shadow of the control bits; only privileged writes may move them
    always_comb
    begin
        next_ctrl = ctrl;
        if (i_wr && i_priv && i_addr == OFS_CTRL)
        begin
            next_ctrl = i_wdata[1:0];
        end
    end
    always_ff @(posedge i_ref_clk)
        ctrl <= i_rst ? CTRL_RST : next_ctrl;
    // Privileged clear of the summary event flag
    assign det_clr = i_wr && i_priv && i_addr == OFS_DET && i_wdata[DET_SUMMARY];

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    a_det_reset: assert property (|i_det && ctrl[0] |=> o_sys_reset[*8] ##1 o_sys_reset[*2])
        else $error("reset reaction not held after detector event");
    a_det_flag: assert property (|i_det && !ctrl[0] |=> o_det_alarm)
        else $error("flag reaction missing after detector event");
    a_alarm_sticky: assert property (o_det_alarm && !det_clr |=> o_det_alarm)
        else $error("event flag dropped without clear");
    a_boot_sel: assert property (o_boot_flash == ctrl[CTRL_BOOT])
        else $error("boot source differs from control bit");
    a_normal_stays: assert property (o_lc_normal |=> o_lc_normal)
        else $error("normal mode left");
    a_tcmd_normal: assert property (i_tcmd_valid && o_lc_normal |=> o_tcmd_reject && !o_tcmd_accept)
        else $error("test command not rejected in normal mode");
    a_accept_test: assert property (o_tcmd_accept |-> !$past(o_lc_normal))
        else $error("test command accepted outside test mode");
    a_inval_trap: assert property (i_acc.valid && i_acc.addr >= MEM_TOP |=> o_acc_trap && o_acc_inval)
        else $error("invalid address not flagged");
    a_commit_normal: assert property (o_nvm_set_normal |=> o_lc_normal && !o_nvm_set_normal)
        else $error("commit pulse without normal mode");

    // Main scenarios reached
    c_hold: cover property (o_sys_reset[*8]);
    c_accept: cover property (o_tcmd_accept);
    c_commit: cover property (o_nvm_set_normal);
endmodule
bind smlc_monitor smlc_monitor_chk #(.DET_N(DET_N), .PART_N(PART_N), .MEM_TOP(MEM_TOP), .TEST_KEY(TEST_KEY)) u_chk (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_priv(i_priv), .o_rdata(o_rdata), .i_det(i_det), .i_acc(i_acc), .i_nvm_normal(i_nvm_normal),
    .i_tcmd_valid(i_tcmd_valid), .i_tcmd_func(i_tcmd_func), .o_sys_reset(o_sys_reset),
    .o_det_alarm(o_det_alarm), .o_acc_trap(o_acc_trap), .o_acc_inval(o_acc_inval),
    .o_tcmd_accept(o_tcmd_accept), .o_tcmd_reject(o_tcmd_reject), .o_boot_flash(o_boot_flash),
    .o_lc_normal(o_lc_normal), .o_nvm_set_normal(o_nvm_set_normal));
`default_nettype wire

// file: security_monitor_lifecycle_tb.sv
`timescale 1ns/100ps
`default_nettype none
module security_monitor_lifecycle_tb
    import smlc_pkg::*;
;
    localparam logic [31:0] MTOP = 32'h0010_0000;
    localparam logic [31:0] KEY  = 32'h5A5A_A5A5;
    logic        i_ref_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0, i_rd = 1'b0, i_priv = 1'b0;
    logic [7:0]  i_det = 8'h00;
    smlc_acc_s   i_acc = '0;
    logic        i_nvm_normal = 1'b0, i_tcmd_valid = 1'b0, i_tcmd_func = 1'b0;
    logic [31:0] o_rdata, d;
    logic        o_sys_reset, o_det_alarm, o_acc_trap, o_acc_inval, o_tcmd_accept;
    logic        o_tcmd_reject, o_boot_flash, o_lc_normal, o_nvm_set_normal;
    int          failures = 0;
    int          check_count = 0;
    int          n, b;
    logic [31:0] a;

    always #5 i_ref_clk = ~i_ref_clk;

    smlc_monitor #(.MEM_TOP(MTOP), .TEST_KEY(KEY)) dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_priv(i_priv), .o_rdata(o_rdata), .i_det(i_det), .i_acc(i_acc), .i_nvm_normal(i_nvm_normal),
        .i_tcmd_valid(i_tcmd_valid), .i_tcmd_func(i_tcmd_func), .o_sys_reset(o_sys_reset),
        .o_det_alarm(o_det_alarm), .o_acc_trap(o_acc_trap), .o_acc_inval(o_acc_inval),
        .o_tcmd_accept(o_tcmd_accept), .o_tcmd_reject(o_tcmd_reject), .o_boot_flash(o_boot_flash),
        .o_lc_normal(o_lc_normal), .o_nvm_set_normal(o_nvm_set_normal));

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic report_and_stop;
        if (failures == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Address of a partition register
    function automatic logic [7:0] pa(input int i, input logic [7:0] o);
        return OFS_PART + 8'(i) * PART_STRIDE + o;
    endfunction

    // Only partition 0 grants anything: user read of 0x100..0x1FF
    function automatic logic trap_of(input logic [31:0] x, input logic w, input logic u);
        return x >= MTOP || (u && (w || x < 32'h100 || x > 32'h1FF));
    endfunction

    // Register write; a gap cycle follows so strobes never collide
    task automatic wr(input logic [7:0] ad, input logic [31:0] v, input logic p);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= ad;
        i_wdata <= v;
        i_priv <= p;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    // Register read compared in the single cycle the data stands
    task automatic rc(input string nm, input logic [7:0] ad, input logic p, input logic [31:0] e);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= ad;
        i_priv <= p;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 chk(nm, o_rdata, e);
    endtask

    task automatic ac(input logic [31:0] x, input logic w, input logic u, input logic iv);
        @(posedge i_ref_clk);
        i_acc <= '{1'b1, x, w, u};
        @(posedge i_ref_clk);
        i_acc.valid <= 1'b0;
        #1 chk("trap", o_acc_trap, trap_of(x, w, u));
        chk("inval", o_acc_inval, iv);
    endtask

    task automatic tc(input logic ea);
        @(posedge i_ref_clk);
        i_tcmd_valid <= 1'b1;
        i_tcmd_func <= 1'($urandom);
        @(posedge i_ref_clk);
        i_tcmd_valid <= 1'b0;
        #1 chk("accept", o_tcmd_accept, ea);
        chk("reject", o_tcmd_reject, !ea);
    endtask

    // One-cycle detector pulse, then count the cycles held in reset
    task automatic dt(input int k);
        @(posedge i_ref_clk);
        i_det <= 8'(1 << k);
        @(posedge i_ref_clk);
        i_det <= 8'h00;
        n = 0;
        #1;
        while (o_sys_reset === 1'b1 && n < 40)
        begin
            n++;
            @(posedge i_ref_clk);
            #1;
        end
        // A hold that never ends is a failure, not a hang
        if (n >= 40)
        begin
            failures++;
            report_and_stop();
        end
    endtask

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        failures++;
        report_and_stop();
    end

    initial
    begin
        b = $urandom(32'h3EC35273);
        repeat (16) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        #1 chk("boot", o_boot_flash, 0);
        rc("ctrl", OFS_CTRL, 1, 32'(CTRL_RST));
        rc("lc", OFS_LC, 1, 32'h4);
        rc("unmapped", 8'hFC, 1, 0);
        for (int i = 0; i < 4; i++)
        begin
            rc("attr", pa(i, PART_OFS_ATTR), 1, 32'(ATTR_RST));
            rc("limit", pa(i, PART_OFS_LIMIT), 1, LIMIT_RST);
            d = $urandom;
            wr(pa(i, PART_OFS_BASE), d, 1);
            wr(pa(i, PART_OFS_LIMIT), ~d, 0);
            rc("base", pa(i, PART_OFS_BASE), 1, d);
            rc("limit", pa(i, PART_OFS_LIMIT), 1, LIMIT_RST);
            rc("base", pa(i, PART_OFS_BASE), 0, 0);
        end
        wr(OFS_CTRL, 32'h3, 0);
        #1 chk("boot", o_boot_flash, 0);
        wr(OFS_CTRL, 32'h2, 1);
        #1 chk("boot", o_boot_flash, 1);
        // Flag reaction; an all-ones write must not mask detection
        wr(OFS_DET, 32'hFFFF_FFFF, 1);
        b = $urandom_range(7, 0);
        dt(b);
        chk("hold", n, 0);
        chk("alarm", o_det_alarm, 1);
        repeat (5) @(posedge i_ref_clk);
        #1 chk("alarm", o_det_alarm, 1);
        rc("det", OFS_DET, 1, 32'h8000_0000 | (1 << b));
        wr(OFS_DET, 32'hFFFF_FFFF, 0);
        rc("det", OFS_DET, 1, 32'h8000_0000 | (1 << b));
        wr(OFS_DET, 32'hFFFF_FFFF, 1);
        rc("det", OFS_DET, 1, 0);
        chk("alarm", o_det_alarm, 0);
        // Reset reaction
        wr(OFS_CTRL, 32'h3, 1);
        b = $urandom_range(7, 0);
        dt(b);
        chk("hold", n, RST_HOLD_CYC);
        rc("det", OFS_DET, 1, 1 << b);
        // Partition 0 grants user read of 0x100..0x1FF
        wr(pa(0, PART_OFS_BASE), 32'h100, 1);
        wr(pa(0, PART_OFS_LIMIT), 32'h1FF, 1);
        wr(pa(0, PART_OFS_ATTR), 32'h1, 1);
        ac(32'h1FF, 0, 1, 0);
        ac(32'h200, 0, 1, 0);
        ac(32'h100, 1, 1, 0);
        ac(MTOP, 0, 0, 1);
        rc("viol", OFS_VIOL, 1, 32'h3);
        // Clear and a fresh user trap in one cycle: the trap bit must survive
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= OFS_VIOL;
        i_wdata <= 32'h7;
        i_priv <= 1'b1;
        i_acc <= '{1'b1, 32'h200, 1'b0, 1'b1};
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        i_acc.valid <= 1'b0;
        rc("viol", OFS_VIOL, 1, 32'h1);
        wr(OFS_VIOL, 32'h7, 1);
        for (int k = 0; k < 24; k++)
        begin
            a = (k % 4 == 0) ? MTOP - 2 + $urandom_range(3, 0) : $urandom_range(32'h2FF, 0);
            ac(a, 1'($urandom), 1'($urandom), a >= MTOP);
        end
        wr(OFS_VIOL, 32'h7, 1);
        // Lifecycle: locked, wrong key, right key, commit to normal
        tc(0);
        wr(OFS_KEY, ~KEY, 1);
        rc("viol", OFS_VIOL, 1, 32'h4);
        tc(0);
        wr(OFS_KEY, KEY, 1);
        rc("lc", OFS_LC, 1, 32'h6);
        tc(1);
        d = $urandom;
        wr(OFS_TRACE, d, 1);
        rc("trace", OFS_TRACE, 0, d);
        wr(OFS_LC, 32'h1, 1);
        #1 chk("commit", o_nvm_set_normal, 1);
        @(posedge i_ref_clk);
        #1 chk("commit", o_nvm_set_normal, 0);
        tc(0);
        wr(OFS_TRACE, ~d, 1);
        rc("trace", OFS_TRACE, 1, d);
        wr(OFS_KEY, KEY, 1);
        rc("lc", OFS_LC, 1, 32'h5);
        // Second reset with storage holding normal mode
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        i_nvm_normal <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        // A privileged in-range access while the lifecycle loads is trapped
        i_acc <= '{1'b1, 32'h100, 1'b0, 1'b0};
        @(posedge i_ref_clk);
        i_acc.valid <= 1'b0;
        #1 chk("trap", o_acc_trap, 1);
        @(posedge i_ref_clk);
        #1 chk("normal", o_lc_normal, 1);
        tc(0);
        report_and_stop();
    end
endmodule
`default_nettype wire
